// file: dv/hc_irq_disable_frame_interval_test.sv
// hc_irq_disable_frame_interval_test: both ends joined by hfi_bus_if.
// assumes a shortened default frame length; user sides driven at negedge.
`timescale 1ns/1ps
module hc_irq_disable_frame_interval_test;
  localparam logic [13:0] PER_DEF = 14'h0014; // short frame keeps run brief
  logic        sys_clk_in, rst_n_in, bit_tick_in, soft_reset_in;
  logic        req_valid_in, restore_in, irq, sof, tog, gate, busy, rsp_v;
  logic        sof_seen;
  logic [6:0]  event_pend_in;
  logic [7:0]  req_code_in;
  logic [13:0] cnt;
  logic [14:0] pkt;
  logic [31:0] req_data_in, rsp_d, rd, saved;
  int          num_errors, check_count;

  hfi_bus_if bus ();
  hfi_dev #(.PER_DEFAULT(PER_DEF)) u_hfi_dev (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .bus(bus), .bit_tick_in(bit_tick_in),
    .soft_reset_in(soft_reset_in), .event_pend_in(event_pend_in),
    .irq_out(irq), .sof_out(sof), .frame_countdown_out(cnt),
    .countdown_toggle_out(tog), .pkt_budget_out(pkt),
    .master_gate_out(gate));
  hfi_host u_hfi_host (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .bus(bus), .req_valid_in(req_valid_in), .req_code_in(req_code_in),
    .req_data_in(req_data_in), .restore_in(restore_in), .busy_out(busy),
    .resp_valid_out(rsp_v), .resp_data_out(rsp_d), .saved_fpc_out(saved));
  hfi_props u_hfi_props (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .cmd_stb(bus.cmd_stb), .cmd_code(bus.cmd_code), .wdata(bus.wdata),
    .rdata(bus.rdata), .rvalid(bus.rvalid));

  always #12.5 sys_clk_in = ~sys_clk_in;
  // the pulse is one cycle wide, so latch it rather than sample later
  always @(posedge sys_clk_in) if (sof === 1'b1) sof_seen <= 1'b1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one host request; returns once busy drops, read word in rdo
  task automatic req(input logic [7:0] code, input logic [31:0] data,
                     input logic rst, output logic [31:0] rdo);
    int n;
    @(negedge sys_clk_in);
    req_valid_in = !rst;
    restore_in = rst;
    req_code_in = code;
    req_data_in = data;
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    restore_in = 1'b0;
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge sys_clk_in);
    rdo = rsp_d;
    chk(32'(rsp_v), 32'(!code[7] && !rst));
    // busy drops at the strobe edge; a write lands one edge later
    @(negedge sys_clk_in);
  endtask : req

  task automatic pulse(input int which);
    @(negedge sys_clk_in);
    if (which == 0) bit_tick_in = 1'b1;
    else soft_reset_in = 1'b1;
    @(negedge sys_clk_in);
    bit_tick_in = 1'b0;
    soft_reset_in = 1'b0;
  endtask : pulse

  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    {sys_clk_in, rst_n_in, bit_tick_in, soft_reset_in} = 4'h0;
    {req_valid_in, restore_in, sof_seen} = 3'h0;
    event_pend_in = 7'h00;
    req_code_in = 8'h00;
    req_data_in = 32'h0000_0000;
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_n_in = 1'b1;
    chk(32'(gate), 32'h0000_0001);
    req(hfi_pkg::FPC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, {18'h0_0000, PER_DEF});
    req(hfi_pkg::IMC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, 32'h8000_0000);
    req(8'h0E, 32'h0000_0000, 1'b0, rd);
    chk(rd, 32'h0000_0000);
    req(hfi_pkg::FPC_WR, 32'h0123_0005, 1'b0, rd);
    req(hfi_pkg::FPC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, 32'h8123_0005);
    $display("test reset and access done");
    for (int n = 0; n < 40 && cnt !== 14'h0000; n++) pulse(0);
    pulse(0);
    chk(32'(tog), 32'h0000_0001);
    pulse(0);
    chk(32'(cnt), 32'h0000_0005);
    chk(32'(pkt), 32'h0000_0123);
    pulse(0);
    chk(32'(cnt), 32'h0000_0004);
    chk(32'(sof_seen), 32'h0000_0001);
    req(hfi_pkg::FPC_WR, 32'h0123_0005, 1'b0, rd);
    req(hfi_pkg::FPC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, 32'h0123_0005);
    $display("test frame done");
    req(hfi_pkg::IME_WR, 32'h0000_007F, 1'b0, rd);
    event_pend_in = 7'h02;
    @(negedge sys_clk_in);
    chk(32'(irq), 32'h0000_0000);
    for (int b = 0; b < 7; b++) if (b != 1) begin
      event_pend_in = 7'(1 << b);
      @(negedge sys_clk_in);
      chk(32'(irq), 32'h0000_0001);
      req(hfi_pkg::IMC_WR, 32'(1 << b), 1'b0, rd);
      chk(32'(irq), 32'h0000_0000);
      req(hfi_pkg::IME_WR, 32'(1 << b), 1'b0, rd);
    end
    event_pend_in = 7'h7D;
    req(hfi_pkg::IMC_WR, 32'h0000_0000, 1'b0, rd);
    chk(32'(irq), 32'h0000_0001);
    req(hfi_pkg::IMC_WR, 32'h8000_0000, 1'b0, rd);
    chk(32'(irq), 32'h0000_0000);
    chk(32'(gate), 32'h0000_0000);
    req(hfi_pkg::IMC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, 32'h0000_007D);
    $display("test interrupt gate done");
    pulse(1);
    chk(32'(gate), 32'h0000_0001);
    req(hfi_pkg::FPC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, {1'b0, 15'h0123, 2'b00, PER_DEF});
    req(hfi_pkg::FPC_WR, 32'h0123_0007, 1'b0, rd);
    pulse(1);
    req(8'h00, 32'h0000_0000, 1'b1, rd);
    req(hfi_pkg::FPC_RD, 32'h0000_0000, 1'b0, rd);
    chk(rd, 32'h0123_0007);
    chk(saved, 32'h0123_0007);
    $display("test soft reset done");
    final_report();
  end
endmodule : hc_irq_disable_frame_interval_test

// file: dv/hfi_props.sv
// hfi_props: bus checks between the driver end and the controller end.
// assumes its inputs come straight from the single hfi_bus_if instance.
`timescale 1ns/1ps
module hfi_props (
  input wire logic        sys_clk_in, // controller clock
  input wire logic        rst_n_in,   // async reset, low
  input wire logic        cmd_stb,    // command strobe
  input wire logic [7:0]  cmd_code,   // command code
  input wire logic [31:0] wdata,      // write word
  input wire logic [31:0] rdata,      // read word
  input wire logic        rvalid      // read answer
);
  logic [31:0] last_fpc_r; // last frame config word sent

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // toggle and packet fields survive soft reset, so only they are compared
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) last_fpc_r <= hfi_pkg::FPC_RST;
    else if (cmd_stb && cmd_code == hfi_pkg::FPC_WR) last_fpc_r <= wdata;
  end

  AST_RD_ANSWER: assert property (cmd_stb && !cmd_code[7] |=> rvalid)
    else $error("read not answered next cycle");
  AST_WR_QUIET: assert property (cmd_stb && cmd_code[7] |=> !rvalid)
    else $error("write produced a read answer");
  AST_RVALID_CAUSE: assert property (rvalid |->
    $past(cmd_stb) && !$past(cmd_code[7]))
    else $error("read answer without a read");
  AST_RDATA_HOLD: assert property (!rvalid |-> $stable(rdata))
    else $error("read word moved without an answer");
  AST_FPC_RSVD: assert property (rvalid &&
    $past(cmd_code) == hfi_pkg::FPC_RD |-> rdata[15:14] == 2'b00)
    else $error("frame config reserved bits set");
  AST_IMC_RSVD: assert property (rvalid &&
    $past(cmd_code) == hfi_pkg::IMC_RD |->
    rdata[30:7] == 24'h00_0000 && !rdata[1])
    else $error("mask reserved bits set");
  AST_UNMAPPED: assert property (rvalid &&
    $past(cmd_code) != hfi_pkg::FPC_RD &&
    $past(cmd_code) != hfi_pkg::IMC_RD |-> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_FPC_BACK: assert property (rvalid &&
    $past(cmd_code) == hfi_pkg::FPC_RD |->
    rdata[31:16] == last_fpc_r[31:16])
    else $error("frame config upper fields lost");

  COV_FPC_RD: cover property (rvalid && $past(cmd_code) == hfi_pkg::FPC_RD);
  COV_FPC_WR: cover property (cmd_stb && cmd_code == hfi_pkg::FPC_WR);
  COV_IMC_WR: cover property (cmd_stb && cmd_code == hfi_pkg::IMC_WR);
endmodule : hfi_props

// file: pkg/hfi_bus_if.sv
// hfi_bus_if: command-code processor bus between driver and controller.
// assumes both ends share one clock; no tristate, one word per command.
`timescale 1ns/1ps
interface hfi_bus_if;
  logic        cmd_stb;   // one-cycle command strobe
  logic [7:0]  cmd_code;  // command code, valid with cmd_stb
  logic [31:0] wdata;     // write word, valid with cmd_stb
  logic [31:0] rdata;     // read word, valid with rvalid
  logic        rvalid;    // one-cycle read answer

  modport dev (
    input  cmd_stb,
    input  cmd_code,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output cmd_stb,
    output cmd_code,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface : hfi_bus_if

// file: pkg/hfi_pkg.sv
// hfi_pkg: command codes, field positions and reset values shared by the
// controller end and the driver end of the frame interval register block.
// assumes both ends run on one controller clock and meet in hfi_bus_if.
package hfi_pkg;

  // command codes; bit 7 set marks a write
  localparam int         WR_BIT = 7;
  localparam logic [7:0] FPC_RD = 8'h0D;
  localparam logic [7:0] FPC_WR = 8'h8D;
  localparam logic [7:0] IMC_RD = 8'h05;
  localparam logic [7:0] IMC_WR = 8'h85;
  localparam logic [7:0] IME_WR = 8'h84;

  // interrupt mask clear layout
  localparam int         GATE_BIT   = 31;
  localparam int         HUB_BIT    = 6;
  localparam int         WRAP_BIT   = 5;
  localparam int         FATAL_BIT  = 4;
  localparam int         RESUME_BIT = 3;
  localparam int         SOF_BIT    = 2;
  localparam int         OVR_BIT    = 0;
  localparam int         EVT_W      = 7;
  localparam logic [6:0] EVT_MASK   = 7'h7D;
  localparam logic       GATE_RST   = 1'b1;
  localparam logic [6:0] ENA_RST    = 7'h00;

  // frame period config layout
  localparam int          TOG_BIT = 31;
  localparam int          PKT_MSB = 30;
  localparam int          PKT_LSB = 16;
  localparam int          PER_MSB = 13;
  localparam int          PER_W   = 14;
  localparam int          PKT_W   = 15;
  localparam logic [31:0] FPC_RST = 32'h0000_2EDF;

endpackage : hfi_pkg

// file: verilog/hfi_dev.sv
// hfi_dev: controller end holding the interrupt gate state and the frame
// period configuration, plus the frame countdown that consumes it.
// assumes bit_tick_in is a one-cycle pulse per bit time on sys_clk_in and
// that event levels come from a status register on the same clock.
//
// Operation
// - master gate write one stops all events
// - zero writes leave enable state unchanged
// - master gate set after either reset
// - bits 6,5,4 disable hub, wrap, error
// - bits 3,2,0 disable resume, sof, overrun
// - frame config read 0D, write 8D
// - bits 13:0 frame length, default 11999
// - load largest packet count each frame
// - driver computes the largest packet value; hfi_host takes it from the caller
// - driver inverts toggle on every write
// - driver may trim interval each frame
// - soft reset restores default frame length
// - driver saves and restores interval over reset
// - countdown per bit time, reload after zero
// - copy toggle into countdown toggle at zero
`timescale 1ns/1ps
module hfi_dev #(
  parameter logic [13:0] PER_DEFAULT = hfi_pkg::FPC_RST[13:0]
) (
  input  wire logic        sys_clk_in,           // controller clock
  input  wire logic        rst_n_in,             // async reset, low
  hfi_bus_if.dev           bus,                  // processor command bus
  input  wire logic        bit_tick_in,          // one pulse per bit time
  input  wire logic        soft_reset_in,        // controller_soft_reset
  input  wire logic [6:0]  event_pend_in,        // pending event levels
  output logic             irq_out,              // interrupt request
  output logic             sof_out,              // start of frame pulse
  output logic [13:0]      frame_countdown_out,  // bit times left
  output logic             countdown_toggle_out, // toggle in use
  output logic [14:0]      pkt_budget_out,       // largest packet counter
  output logic             master_gate_out       // master_irq_gate state
);

  // a zero default would make every frame a bare zero and reload tick,
  // leaving no bit times for any transfer at all
  if (PER_DEFAULT == 14'h0000) begin : g_bad_default
    $error("hfi_dev: PER_DEFAULT must be non-zero");
  end

  // the field constants and the record widths must agree, or the word
  // images below would push one field into its neighbour
  if (hfi_pkg::PKT_W != hfi_pkg::PKT_MSB - hfi_pkg::PKT_LSB + 1 ||
      hfi_pkg::PER_W != hfi_pkg::PER_MSB + 1) begin : g_bad_layout
    $error("hfi_dev: field layout constants disagree");
  end

  // the whole block state in one record: the two register images, the
  // frame countdown they feed and the registered bus answer; one comb
  // process builds the next record and one flop process holds it, so
  // no field can be left behind when the state is copied or reset
  typedef struct packed {
    logic        gate;     // master_irq_gate enable
    logic [6:0]  ena;      // per-event enables
    logic        tog;      // interval_toggle
    logic [14:0] pkt;      // largest_packet_bits
    logic [13:0] per;      // frame_period_bits
    logic [13:0] remain;   // frame_countdown
    logic        rtog;     // countdown_toggle
    logic        reload;   // zero reached, reload on next tick
    logic [14:0] pkt_cnt;  // largest data packet counter
    logic        sof;      // start of frame pulse
    logic        irq;      // registered interrupt request
    logic        rvalid;   // read answer pulse
    logic [31:0] rdata;    // read answer word, held until next read
  } hfi_dev_st_t;

  hfi_dev_st_t r; // current state
  hfi_dev_st_t n; // next state

  // word images of the two readable registers
  function automatic logic [31:0] fpc_word(input hfi_dev_st_t s);
    fpc_word = {s.tog, s.pkt, 2'b00, s.per};
  endfunction : fpc_word

  function automatic logic [31:0] imc_word(input hfi_dev_st_t s);
    imc_word = {s.gate, 24'h00_0000, s.ena};
  endfunction : imc_word

  // event bits of a written word, shared by the set and clear sides;
  // reserved bit 1 never reaches the enables, so a stray one there
  // cannot open a source that has no event behind it
  function automatic logic [6:0] evt_bits(input logic [31:0] w);
    evt_bits = w[6:0] & hfi_pkg::EVT_MASK;
  endfunction : evt_bits

  // next-state logic for registers, countdown and interrupt
  always_comb begin
    n        = r;
    n.rvalid = 1'b0;
    n.sof    = 1'b0;

    // processor commands; writes take effect on the strobe edge, and
    // one strobe carries one code, so the branches never overlap
    if (bus.cmd_stb) begin
      if (bus.cmd_code == hfi_pkg::FPC_WR) begin
        // all three fields move together so the toggle marks the change
        n.tog = bus.wdata[hfi_pkg::TOG_BIT];
        n.pkt = bus.wdata[hfi_pkg::PKT_MSB:hfi_pkg::PKT_LSB];
        n.per = bus.wdata[hfi_pkg::PER_MSB:0];
      end

      if (bus.cmd_code == hfi_pkg::IMC_WR) begin
        // only ones act; zeros keep the current enable state, so the
        // driver can close one source without reading the others first
        if (bus.wdata[hfi_pkg::GATE_BIT]) begin
          n.gate = 1'b0;
        end
        n.ena = r.ena & ~evt_bits(bus.wdata);
      end

      if (bus.cmd_code == hfi_pkg::IME_WR) begin
        // set side of the mask, kept so the disables can be undone; the
        // disable register on its own could only ever close sources
        if (bus.wdata[hfi_pkg::GATE_BIT]) begin
          n.gate = 1'b1;
        end
        n.ena = r.ena | evt_bits(bus.wdata);
      end

      // reads answer one cycle later; unmapped codes read zero so the
      // driver can probe for registers that this block does not hold
      if (!bus.cmd_code[hfi_pkg::WR_BIT]) begin
        n.rvalid = 1'b1;
        if (bus.cmd_code == hfi_pkg::FPC_RD) begin
          n.rdata = fpc_word(r);
        end else if (bus.cmd_code == hfi_pkg::IMC_RD) begin
          n.rdata = imc_word(r);
        end else begin
          n.rdata = 32'h0000_0000;
        end
      end
    end

    // frame countdown, advancing only on bit-time boundaries; a frame
    // spans the period plus the zero tick and the reload tick
    if (bit_tick_in) begin
      if (r.reload) begin
        // next boundary after zero starts a new frame, and the packet
        // budget is refilled so every frame opens with its full allowance
        n.remain  = r.per;
        n.pkt_cnt = r.pkt;
        n.reload  = 1'b0;
        n.sof     = 1'b1;
      end else if (r.remain == 14'h0000) begin
        // toggle copied now so the driver sees which period is loading;
        // a write in this very tick loads its period while the copied
        // toggle still shows the old one, so drivers write mid-frame
        n.rtog   = r.tog;
        n.reload = 1'b1;
      end else begin
        // one bit time gone
        n.remain = r.remain - 14'h0001;
      end
    end

    // soft reset wins over a write in the same cycle; countdown, toggle
    // and packet budget keep running so the frame timing stays whole
    if (soft_reset_in) begin
      n.per  = PER_DEFAULT;
      n.gate = hfi_pkg::GATE_RST;
      n.ena  = hfi_pkg::ENA_RST;
    end

    // computed from next state so a disable write masks at once; the
    // request still lags the event level by one flop
    n.irq = n.gate & (|(event_pend_in & n.ena & hfi_pkg::EVT_MASK));
  end

  // state register; reset values are constants only, so the async
  // branch never samples a signal that might itself be settling
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r.gate    <= hfi_pkg::GATE_RST;
      r.ena     <= hfi_pkg::ENA_RST;
      r.tog     <= hfi_pkg::FPC_RST[hfi_pkg::TOG_BIT];
      r.pkt     <= hfi_pkg::FPC_RST[hfi_pkg::PKT_MSB:hfi_pkg::PKT_LSB];
      r.per     <= PER_DEFAULT;
      r.remain  <= PER_DEFAULT;
      r.rtog    <= 1'b0;
      r.reload  <= 1'b0;
      r.pkt_cnt <= 15'h0000;
      r.sof     <= 1'b0;
      r.irq     <= 1'b0;
      r.rvalid  <= 1'b0;
      r.rdata   <= 32'h0000_0000;
    end else begin
      r <= n;
    end
  end

  // every output is a flop of the state record, so no output carries
  // a combinational path back to the bus or the event inputs, and the
  // host end may sample them at any edge without a settling hazard
  assign bus.rvalid           = r.rvalid;
  assign bus.rdata            = r.rdata;
  assign irq_out              = r.irq;
  assign sof_out              = r.sof;
  assign frame_countdown_out  = r.remain;
  assign countdown_toggle_out = r.rtog;
  assign pkt_budget_out       = r.pkt_cnt;
  assign master_gate_out      = r.gate;

endmodule : hfi_dev

// file: verilog/hfi_host.sv
// hfi_host: driver end issuing command-code reads and writes, keeping the
// interval toggle and a saved copy of the frame period across soft resets.
// assumes one request at a time, offered only while busy_out is low.
`timescale 1ns/1ps
module hfi_host (
  input  wire logic        sys_clk_in,     // controller clock
  input  wire logic        rst_n_in,       // async reset, low
  hfi_bus_if.host          bus,            // processor command bus
  input  wire logic        req_valid_in,   // request strobe
  input  wire logic [7:0]  req_code_in,    // command code
  input  wire logic [31:0] req_data_in,    // write word
  input  wire logic        restore_in,     // write saved period back
  output logic             busy_out,       // request in flight
  output logic             resp_valid_out, // read answer pulse
  output logic [31:0]      resp_data_out,  // read answer word
  output logic [31:0]      saved_fpc_out   // last known period config
);

  typedef enum logic [1:0] {
    HFI_IDLE = 2'b00,
    HFI_SEND = 2'b01,
    HFI_WAIT = 2'b10
  } hfi_hst_e_t;

  typedef struct packed {
    hfi_hst_e_t  st;
    logic        stb;
    logic [7:0]  code;
    logic [31:0] wdata;
    logic        busy;
    logic        rv;
    logic [31:0] rd;
    logic [31:0] saved;
  } hfi_host_st_t;

  hfi_host_st_t r;
  hfi_host_st_t n;

  // command sequencer: take, strobe, then wait for a read answer
  always_comb begin
    n     = r;
    n.stb = 1'b0;
    n.rv  = 1'b0;
    unique case (r.st)
      HFI_IDLE: begin
        if (restore_in) begin
          // restore carries a fresh toggle so the change is visible
          n.code  = hfi_pkg::FPC_WR;
          n.wdata = r.saved ^ 32'h8000_0000;
          n.saved = n.wdata;
          n.st    = HFI_SEND;
          n.busy  = 1'b1;
        end else if (req_valid_in) begin
          n.code  = req_code_in;
          n.wdata = req_data_in;
          if (req_code_in == hfi_pkg::FPC_WR) begin
            // caller picks period and budget, toggle is ours
            n.wdata[hfi_pkg::TOG_BIT] = ~r.saved[hfi_pkg::TOG_BIT];
            n.saved = n.wdata;
          end
          n.st   = HFI_SEND;
          n.busy = 1'b1;
        end
      end
      HFI_SEND: begin
        n.stb = 1'b1;
        if (r.code[hfi_pkg::WR_BIT]) begin
          n.st = HFI_IDLE;
        end else begin
          n.st = HFI_WAIT;
        end
      end
      HFI_WAIT: begin
        if (bus.rvalid) begin
          n.rv = 1'b1;
          n.rd = bus.rdata;
          if (r.code == hfi_pkg::FPC_RD) begin
            n.saved = bus.rdata;
          end
          n.st   = HFI_IDLE;
        end
      end
      default: begin
        n.st = HFI_IDLE;
      end
    endcase
    // busy drops in the cycle the sequencer returns to idle
    if (r.st == HFI_SEND && r.code[hfi_pkg::WR_BIT]) begin
      n.busy = 1'b0;
    end
    if (r.st == HFI_WAIT && bus.rvalid) begin
      n.busy = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r.st    <= HFI_IDLE;
      r.stb   <= 1'b0;
      r.code  <= 8'h00;
      r.wdata <= 32'h0000_0000;
      r.busy  <= 1'b0;
      r.rv    <= 1'b0;
      r.rd    <= 32'h0000_0000;
      r.saved <= hfi_pkg::FPC_RST;
    end else begin
      r <= n;
    end
  end

  assign bus.cmd_stb     = r.stb;
  assign bus.cmd_code    = r.code;
  assign bus.wdata       = r.wdata;
  assign busy_out        = r.busy;
  assign resp_valid_out  = r.rv;
  assign resp_data_out   = r.rd;
  assign saved_fpc_out   = r.saved;

endmodule : hfi_host
